// ==== fsg_defines.vh ====
// Constants for the flash security command gate: register map, fields, opcodes.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
`ifndef FSG_DEFINES_VH
`define FSG_DEFINES_VH

// Register byte offsets
`define FSG_REG_CMD 8'h00
`define FSG_REG_ADDR 8'h04
`define FSG_REG_DATA 8'h08
`define FSG_REG_SEC 8'h0c
`define FSG_REG_STAT 8'h10

// Command opcodes in CMD[2:0]
`define FSG_OP_CHIP_ERASE 3'h1
`define FSG_OP_BLOCK_ERASE 3'h2
`define FSG_OP_WRITE 3'h3
`define FSG_OP_SEC_SET 3'h4

// Protection flag bit positions
`define FSG_F_NO_CHIP 0
`define FSG_F_NO_BLOCK 1
`define FSG_F_NO_WRITE 2
`define FSG_F_BOOT_LOCK 3

// Status register fields
`define FSG_ST_BUSY 0
`define FSG_ST_DONE 1
`define FSG_ST_NAK 2
`define FSG_ST_MODE 3
`define FSG_ST_ACT_LSB 4
`define FSG_ST_STO_LSB 8

// Startup region bounds
`define FSG_BOOT_LO 16'h0000
`define FSG_BOOT_HI 16'h0fff

// Factory state of the protection flags
`define FSG_FLAGS_RST 4'h0

`endif

// ==== fsg_flash_model.sv ====
// Flash array stand-in: a done pulse a few cycles after each strobe.
// Assumes the gate issues one strobe at a time.
module fsg_flash_model (
	// Clock and strobes
	input wire ref_clk,
	input wire fl_chip_erase,
	input wire fl_block_erase,
	input wire fl_write,
	// Completion
	output logic fl_done
);
	timeunit 1ns;
	timeprecision 1ns;
	int w = -1;
	always @(posedge ref_clk) begin
		fl_done <= w == 0;
		if (fl_chip_erase | fl_block_erase | fl_write)
			w <= $urandom % 4;
		else if (w >= 0)
			w <= w - 1;
	end
endmodule

// ==== fsg_gate.v ====
// Flash security command gate: Wishbone command port, protection flags, flash strobes.
// Assumes a flash array that answers each erase or write strobe with a done pulse.
//
// Overview of operation
// - Flags are set only through the security set command.
// - Newly set flags gate commands only after next programming mode entry.
// - No-chip-erase refuses chip erase and every block erase.
// - Once no-chip-erase is stored, no flag can ever be cleared.
// - No-block-erase refuses block erase only; chip erase and write still run.
// - No-write refuses writes and block erases; chip erase may still run.
// - Boot lock refuses erase and write in 0000H-0FFFH and chip erase.
// - Boot lock, once set, has no way to be cleared.
// - An executed chip erase clears no-block-erase and no-write flags unless no-chip-erase is stored.
// - Factory state has all four flags inactive.
// - Flags are independent; any active flag that forbids refuses the command.
// - Programmer starts every transfer; device only answers commands.
module fsg_gate #(
	parameter AW = 8,
	parameter FA_W = 16,
	parameter FD_W = 8
) (
	// Clock and reset
	input wire ref_clk,
	input wire sys_rst,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [AW-1:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Programming mode level, high while in programming mode
	input wire prog_mode,
	// Flash array strobes
	output reg fl_chip_erase,
	output reg fl_block_erase,
	output reg fl_write,
	output reg [FA_W-1:0] fl_addr,
	output reg [FD_W-1:0] fl_wdata,
	input wire fl_done
);
`include "fsg_defines.vh"

	localparam ST_IDLE = 2'h0;
	localparam ST_EVAL = 2'h1;
	localparam ST_WAIT = 2'h2;
	localparam [3:0] FLAGS_RST = `FSG_FLAGS_RST;

	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [2:0] op_r;
	reg [FA_W-1:0] addr_r;
	reg [FD_W-1:0] data_r;
	reg [3:0] sec_arg_r;
	wire [3:0] stored_r;
	wire [3:0] active_r;
	reg mode_d_r;
	reg done_r;
	reg nak_r;
	reg start_r;

	wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire bus_wr = bus_req && wb_we_i;
	wire mode_entry = prog_mode && !mode_d_r;
	// Register writes are shut while a command is pending or running
	wire wr_open = bus_wr && (state_r == ST_IDLE) && !start_r;

	// Startup region match for erase and write targets
	function in_boot;
		input [FA_W-1:0] a;
		begin
			in_boot = (a >= `FSG_BOOT_LO) && (a <= `FSG_BOOT_HI);
		end
	endfunction

	// What one flag forbids, looked at on its own
	function forbids;
		input integer idx;
		input [2:0] op;
		input [FA_W-1:0] a;
		begin
			forbids = 1'b0;
			case (idx)
			`FSG_F_NO_CHIP: begin
				forbids = (op == `FSG_OP_CHIP_ERASE) || (op == `FSG_OP_BLOCK_ERASE);
			end
			`FSG_F_NO_BLOCK: begin
				forbids = (op == `FSG_OP_BLOCK_ERASE);
			end
			`FSG_F_NO_WRITE: begin
				forbids = (op == `FSG_OP_WRITE) || (op == `FSG_OP_BLOCK_ERASE);
			end
			`FSG_F_BOOT_LOCK: begin
				forbids = (op == `FSG_OP_CHIP_ERASE) ||
					(((op == `FSG_OP_BLOCK_ERASE) || (op == `FSG_OP_WRITE)) && in_boot(a));
			end
			default: begin
				forbids = 1'b0;
			end
			endcase
		end
	endfunction

	function refused;
		input [2:0] op;
		input [3:0] f;
		input [FA_W-1:0] a;
		integer i;
		begin
			// Unknown opcodes are refused outright
			refused = !((op == `FSG_OP_CHIP_ERASE) || (op == `FSG_OP_BLOCK_ERASE) ||
				(op == `FSG_OP_WRITE) || (op == `FSG_OP_SEC_SET));
			for (i = 0; i < 4; i = i + 1) begin
				if (f[i] && forbids(i, op, a))
					refused = 1'b1;
			end
		end
	endfunction

	function lifts_on_erase;
		input integer idx;
		begin
			lifts_on_erase = (idx == `FSG_F_NO_BLOCK) || (idx == `FSG_F_NO_WRITE);
		end
	endfunction

	// Register write decode shared by the writable registers
	function wr_hit;
		input [AW-1:0] adr;
		input [AW-1:0] off;
		input sel;
		begin
			wr_hit = (adr == off) && sel;
		end
	endfunction

	// Status word from bit 0 upward: busy, done, nak, mode, active, stored
	function [31:0] status_word;
		input [3:0] st;
		input [3:0] act;
		input mode;
		input nak;
		input done;
		input busy;
		begin
			status_word = {20'h00000, st, act, mode, nak, done, busy};
		end
	endfunction

	// Outside programming mode every command is refused, security set included,
	// so a running system can never touch the flags behind the programmer's back.
	wire deny = !prog_mode || refused(op_r, active_r, addr_r);

	// Wishbone answer one cycle after the request, for any address
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wb_dat_o <= 32'h00000000;
		end else if (bus_req && !wb_we_i) begin
			case (wb_adr_i)
			`FSG_REG_CMD: wb_dat_o <= {29'h0000000, op_r};
			`FSG_REG_ADDR: wb_dat_o <= {{(32-FA_W){1'b0}}, addr_r};
			`FSG_REG_DATA: wb_dat_o <= {{(32-FD_W){1'b0}}, data_r};
			`FSG_REG_SEC: wb_dat_o <= {28'h0000000, sec_arg_r};
			`FSG_REG_STAT: wb_dat_o <= status_word(stored_r, active_r, prog_mode, nak_r, done_r,
				(state_r != ST_IDLE));
			default: wb_dat_o <= 32'h00000000;
			endcase
		end
	end

	// Operand registers; held steady while a command runs
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			addr_r <= {FA_W{1'b0}};
			data_r <= {FD_W{1'b0}};
			sec_arg_r <= 4'h0;
		end else if (wr_open) begin
			if (wr_hit(wb_adr_i, `FSG_REG_ADDR, wb_sel_i[0]))
				addr_r[7:0] <= wb_dat_i[7:0];
			if (wr_hit(wb_adr_i, `FSG_REG_ADDR, wb_sel_i[1]))
				addr_r[FA_W-1:8] <= wb_dat_i[FA_W-1:8];
			if (wr_hit(wb_adr_i, `FSG_REG_DATA, wb_sel_i[0]))
				data_r <= wb_dat_i[FD_W-1:0];
			if (wr_hit(wb_adr_i, `FSG_REG_SEC, wb_sel_i[0]))
				sec_arg_r <= wb_dat_i[3:0];
		end
	end

	// only a bus write to CMD starts work; busy writes are ignored
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			op_r <= 3'h0;
			start_r <= 1'b0;
		end else begin
			start_r <= 1'b0;
			if (wr_open && wr_hit(wb_adr_i, `FSG_REG_CMD, wb_sel_i[0])) begin
				op_r <= wb_dat_i[2:0];
				start_r <= 1'b1;
			end
		end
	end

	always @* begin
		state_nxt = state_r;
		case (state_r)
		ST_IDLE: begin
			if (start_r)
				state_nxt = ST_EVAL;
		end
		ST_EVAL: begin
			if (deny || op_r == `FSG_OP_SEC_SET)
				state_nxt = ST_IDLE;
			else
				state_nxt = ST_WAIT;
		end
		ST_WAIT: begin
			// No timeout: a flash that never answers keeps the gate busy
			if (fl_done)
				state_nxt = ST_IDLE;
		end
		default: begin
			state_nxt = ST_IDLE;
		end
		endcase
	end

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Answer flags; cleared when a new command is taken
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			done_r <= 1'b0;
			nak_r <= 1'b0;
		end else if (start_r) begin
			done_r <= 1'b0;
			nak_r <= 1'b0;
		end else if (state_r == ST_EVAL && deny) begin
			done_r <= 1'b1;
			nak_r <= 1'b1;
		end else if (state_r == ST_EVAL && op_r == `FSG_OP_SEC_SET) begin
			done_r <= 1'b1;
		end else if (state_r == ST_WAIT && fl_done) begin
			done_r <= 1'b1;
		end
	end

	// Flash strobes are one-cycle pulses; a refused command never raises one
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fl_chip_erase <= 1'b0;
			fl_block_erase <= 1'b0;
			fl_write <= 1'b0;
			fl_addr <= {FA_W{1'b0}};
			fl_wdata <= {FD_W{1'b0}};
		end else begin
			fl_chip_erase <= 1'b0;
			fl_block_erase <= 1'b0;
			fl_write <= 1'b0;
			if (state_r == ST_EVAL && !deny) begin
				fl_chip_erase <= (op_r == `FSG_OP_CHIP_ERASE);
				fl_block_erase <= (op_r == `FSG_OP_BLOCK_ERASE);
				fl_write <= (op_r == `FSG_OP_WRITE);
				fl_addr <= addr_r;
				fl_wdata <= data_r;
			end
		end
	end

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode_d_r <= 1'b0;
		end else begin
			mode_d_r <= prog_mode;
		end
	end

	// Gated launches that touch the flags
	wire sec_run = (state_r == ST_EVAL) && !deny && (op_r == `FSG_OP_SEC_SET);
	wire erase_run = (state_r == ST_EVAL) && !deny && (op_r == `FSG_OP_CHIP_ERASE);
	wire erase_lifts = erase_run && !stored_r[`FSG_F_NO_CHIP];

	// Stored bits stand for the nonvolatile copy, so sys_rst models factory state.
	// Limitation: a real part keeps them over power loss, this block does not.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_flag
			reg st_r;
			reg act_r;
			assign stored_r[gi] = st_r;
			assign active_r[gi] = act_r;
			always @(posedge ref_clk or posedge sys_rst) begin
				if (sys_rst) begin
					st_r <= FLAGS_RST[gi];
				end else if (sec_run && sec_arg_r[gi]) begin
					st_r <= 1'b1;
				end else if (erase_lifts && lifts_on_erase(gi)) begin
					st_r <= 1'b0;
				end
			end
			always @(posedge ref_clk or posedge sys_rst) begin
				if (sys_rst) begin
					act_r <= FLAGS_RST[gi];
				end else if (mode_entry) begin
					act_r <= st_r;
				end else if (erase_lifts && lifts_on_erase(gi)) begin
					// Lifted at once so the same session may rewrite the array
					act_r <= 1'b0;
				end
			end
		end
	endgenerate

endmodule

// ==== fsg_gate_sva.sv ====
// Port checker for the command gate.
// Assumes it is bound onto every fsg_gate.
module fsg_gate_sva #(
	parameter AW = 8,
	parameter FA_W = 16
) (
	// Clock and bus
	input wire ref_clk,
	input wire sys_rst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [AW-1:0] wb_adr_i,
	input wire wb_ack_o,
	// Mode and flash
	input wire prog_mode,
	input wire fl_chip_erase,
	input wire fl_block_erase,
	input wire fl_write,
	input wire [FA_W-1:0] fl_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	wire go = fl_chip_erase | fl_block_erase | fl_write;
	wire req = wb_cyc_i & wb_stb_i & !wb_ack_o;
	property p_ack; req |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack1: assert property (p_ack1) else $error("ack too long");
	property p_cause; wb_ack_o |-> $past(wb_stb_i); endproperty
	a_cause: assert property (p_cause) else $error("ack unasked");
	property p_one; $onehot0({fl_chip_erase, fl_block_erase, fl_write}); endproperty
	a_one: assert property (p_one) else $error("two strobes");
	property p_mode; go |-> prog_mode; endproperty
	a_mode: assert property (p_mode) else $error("strobe out of mode");
	// Gating takes two cycles, so no strobe may beat it
	property p_lat; req && wb_we_i && wb_adr_i == 0 |=> !go [*2]; endproperty
	a_lat: assert property (p_lat) else $error("strobe early");
	property p_hold; go |=> $stable(fl_addr); endproperty
	a_hold: assert property (p_hold) else $error("address moved");
	property p_pulse; go |=> !go; endproperty
	a_pulse: assert property (p_pulse) else $error("strobe too long");
	c_wr: cover property (fl_write);
	c_be: cover property (fl_block_erase);
	c_ce: cover property (fl_chip_erase);
endmodule

bind fsg_gate fsg_gate_sva #(.AW(AW), .FA_W(FA_W)) fsg_gate_sva_i (
	.ref_clk(ref_clk),
	.sys_rst(sys_rst),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_ack_o(wb_ack_o),
	.prog_mode(prog_mode),
	.fl_chip_erase(fl_chip_erase),
	.fl_block_erase(fl_block_erase),
	.fl_write(fl_write),
	.fl_addr(fl_addr)
);

// ==== tb_top.sv ====
// Bench for the command gate: bus tasks, expected queues, flash stand-in.
// Assumes the register map and opcodes of fsg_defines.vh.
`include "fsg_defines.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam [2:0] OC = `FSG_OP_CHIP_ERASE, OB = `FSG_OP_BLOCK_ERASE, OW = `FSG_OP_WRITE;
	localparam [2:0] OS = `FSG_OP_SEC_SET, C = 3'h4, B = 3'h2, W = 3'h1;
	logic ref_clk = 0, sys_rst = 1, wb_cyc_i = 0, wb_we_i = 0, prog_mode = 0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0, rd;
	logic [63:0] rq[$];
	logic [26:0] sq[$];
	int miscompares = 0, checks = 0, n = 0;
	wire [31:0] wb_dat_o;
	wire wb_ack_o, fl_chip_erase, fl_block_erase, fl_write, fl_done;
	wire [15:0] fl_addr;
	wire [7:0] fl_wdata;
	wire [2:0] k = {fl_chip_erase, fl_block_erase, fl_write};
	fsg_gate fsg_gate_i (
		.ref_clk(ref_clk), .sys_rst(sys_rst),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_cyc_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .prog_mode(prog_mode),
		.fl_chip_erase(fl_chip_erase), .fl_block_erase(fl_block_erase),
		.fl_write(fl_write), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_done(fl_done));
	fsg_flash_model fsg_flash_model_i (
		.ref_clk(ref_clk), .fl_chip_erase(fl_chip_erase),
		.fl_block_erase(fl_block_erase), .fl_write(fl_write), .fl_done(fl_done));
	initial forever #10 ref_clk = ~ref_clk;
	task automatic cmp(string t, logic [31:0] x, logic [31:0] g);
		checks++;
		if (g !== x) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", t, x, g);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d, miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] m = 0);
		if (!w)
			rq.push_back({m, d});
		wb_cyc_i <= 1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		@(posedge ref_clk);
		while (wb_ack_o !== 1'b1)
			@(posedge ref_clk);
		rd = wb_dat_o;
		wb_cyc_i <= 0;
		@(posedge ref_clk);
	endtask
	// Oldest note against each read and each strobe
	always @(posedge ref_clk) begin
		logic [63:0] e;
		if (wb_ack_o && !wb_we_i) begin
			e = rq.pop_front();
			cmp("read data", e[31:0] & e[63:32], wb_dat_o & e[63:32]);
		end
		if (k) begin
			e = sq.size() ? sq.pop_front() : '1;
			cmp("strobe", fl_write ? e[26:0] : fl_block_erase ? e[26:8] : e[26:24],
				fl_write ? {k, fl_addr, fl_wdata} : fl_block_erase ? {k, fl_addr} : k);
		end
		if (++n == 5000) begin
			miscompares++;
			end_sim;
		end
	end
	// SEC always gets the low address bits; only the set command uses it
	task automatic cmd(logic [2:0] op, logic [15:0] a, logic [2:0] kx, logic f);
		logic [7:0] d;
		d = 8'($urandom);
		if (kx)
			sq.push_back({kx, a, d});
		bus(1, `FSG_REG_ADDR, 32'(a));
		bus(1, `FSG_REG_DATA, 32'(d));
		bus(1, `FSG_REG_SEC, 32'(a[3:0]));
		bus(1, `FSG_REG_CMD, 32'(op));
		rd = 0;
		while (rd[1] !== 1'b1)
			bus(0, `FSG_REG_STAT, 0);
		bus(0, `FSG_REG_STAT, {f, 2'b10}, 32'h7);
	endtask
	task automatic fl(logic [3:0] s, logic [3:0] a);
		bus(0, `FSG_REG_STAT, {s, a, 4'h0}, 32'hff0);
	endtask
	task automatic enter;
		prog_mode <= 0;
		@(posedge ref_clk);
		prog_mode <= 1;
		repeat (2) @(posedge ref_clk);
	endtask
	initial begin
		void'($urandom(2));
		repeat (5) @(posedge ref_clk);
		sys_rst <= 0;
		@(posedge ref_clk);
		fl(4'h0, 4'h0);
		bus(0, 8'h14, 0, '1);
		cmd(OW, 16'h2000, 0, 1);
		enter;
		cmd(OW, 16'h0100, W, 0);
		cmd(OB, 16'h0100, B, 0);
		cmd(OC, 16'h0000, C, 0);
		cmd(3'h7, 16'h0000, 0, 1);
		cmd(OS, 16'h0006, 0, 0);
		fl(4'h6, 4'h0);
		cmd(OB, 16'h2000, B, 0);
		enter;
		cmd(OB, 16'h2000, 0, 1);
		cmd(OW, 16'h1000 + 16'($urandom_range(32'hefff)), 0, 1);
		cmd(OC, 16'h0000, C, 0);
		fl(4'h0, 4'h0);
		cmd(OS, 16'h0008, 0, 0);
		enter;
		cmd(OW, 16'h0fff, 0, 1);
		cmd(OW, 16'h1000, W, 0);
		cmd(OB, 16'h0000, 0, 1);
		cmd(OC, 16'h0000, 0, 1);
		cmd(OS, 16'h0001, 0, 0);
		enter;
		cmd(OB, 16'h2000, 0, 1);
		cmd(OW, 16'h3000, W, 0);
		cmd(OC, 16'h0000, 0, 1);
		cmd(OS, 16'h0000, 0, 0);
		enter;
		fl(4'h9, 4'h9);
		cmp("strobes left", 0, sq.size());
		end_sim;
	end
endmodule
